/* hw/pfm_pkg.sv */
// Purpose: constants shared by the performance monitor counter block
// Assumes: special-register numbers are 10 bits; bit 0 of a register is its msb
// Notes:   field positions below are given as lsb-first indices
// Contract
// - counters mirrored to user views 937-942
// - sampled address loaded near interrupt; 955
// - threshold overflow captures exact instruction address
// - other overflow captures last completed address
// - sampled address mirrored at 939
// - count only when privilege/mark state matches
// - four disable bits select the privilege/mark states counted
// - control bits 0-4 zero counts unconditionally
// - count-disable bit stops all counting
// - msb set means overflow, raises interrupt
// - counter one select field bits 19-25
// - counter two select field bits 26-31
// - codes 0 hold, 1 cycles, 2 completions
// - code 4 adds dispatched instructions per cycle
// - code 3 counts chosen time-base bit rises
// - multi-occurrence events add whole per-cycle amount
// - threshold counts only queue-head loads/stores
// - unaligned, multiple, string threshold not tracked
// - counter three select secondary bits 0-4
// - counter four select secondary bits 5-9
package pfm_pkg;
    localparam logic [9:0]  SPR_UCTR1      = 10'h3A9;
    localparam logic [9:0]  SPR_UCTR2      = 10'h3AA;
    localparam logic [9:0]  SPR_USAMP      = 10'h3AB;
    localparam logic [9:0]  SPR_UCTR3      = 10'h3AD;
    localparam logic [9:0]  SPR_UCTR4      = 10'h3AE;
    localparam logic [9:0]  SPR_CTRL_PRI   = 10'h3B8;
    localparam logic [9:0]  SPR_CTR1       = 10'h3B9;
    localparam logic [9:0]  SPR_CTR2       = 10'h3BA;
    localparam logic [9:0]  SPR_SAMP       = 10'h3BB;
    localparam logic [9:0]  SPR_CTRL_SEC   = 10'h3BC;
    localparam logic [9:0]  SPR_CTR3       = 10'h3BD;
    localparam logic [9:0]  SPR_CTR4       = 10'h3BE;
    // primary control: disable bits (msb-first bits 0..4)
    localparam int          CP_DIS         = 31;
    localparam int          CP_DIS_SUP     = 30;
    localparam int          CP_DIS_USER    = 29;
    localparam int          CP_DIS_MARK    = 28;
    localparam int          CP_DIS_UNMARK  = 27;
    localparam int          CP_TB_LO       = 23;
    localparam int          CP_SEL1_LO     = 6;
    localparam int          CP_SEL2_LO     = 0;
    localparam int          CS_SEL3_LO     = 27;
    localparam int          CS_SEL4_LO     = 22;
    localparam int          TB_BIT0        = 0;
    localparam int          TB_BIT1        = 8;
    localparam int          TB_BIT2        = 12;
    localparam int          TB_BIT3        = 16;
    localparam logic [6:0]  EV_HOLD        = 7'h00;
    localparam logic [6:0]  EV_CYCLES      = 7'h01;
    localparam logic [6:0]  EV_COMPLETE    = 7'h02;
    localparam logic [6:0]  EV_TBRISE      = 7'h03;
    localparam logic [6:0]  EV_DISPATCH    = 7'h04;
    localparam logic [6:0]  EV_THRESHOLD   = 7'h0B;
    localparam int          EXT_CODES      = 32;
    localparam logic [31:0] CTRL_PRI_RST   = 32'h0000_0000;
    localparam logic [31:0] CTRL_SEC_RST   = 32'h0000_0000;
    localparam logic [31:0] CTR_RST        = 32'h0000_0000;
    localparam logic [31:0] SAMP_RST       = 32'h0000_0000;
endpackage

/* hw/pfm_counter.sv */
// Purpose: one 32-bit event counter with software load
// Assumes: amount arrives already selected and gated by the caller
// Notes:   saturates at all ones so a pending overflow cannot wrap away
`timescale 1ns/1ps
module pfm_counter #(
    parameter int WIDTH = 32
) (
    // clock and reset
    input  wire logic             sys_clk,
    input  wire logic             rst,
    // software load
    input  wire logic             wrEn,
    input  wire logic [WIDTH-1:0] wrData,
    // counting
    input  wire logic [2:0]       amount,
    output logic      [WIDTH-1:0] value,
    output logic                  ovfRise
);
    typedef struct packed {
        logic [WIDTH-1:0] cnt;
    } pfm_ctr_s;

    pfm_ctr_s st_r;
    pfm_ctr_s st_nxt;
    logic [WIDTH:0] sum;

    always_comb begin
        st_nxt  = st_r;
        sum     = {1'b0, st_r.cnt} + {{(WIDTH-2){1'b0}}, amount};
        ovfRise = 1'b0;
        if (wrEn) begin
            st_nxt.cnt = wrData;
        end else if (sum[WIDTH]) begin
            st_nxt.cnt = '1;
        end else begin
            st_nxt.cnt = sum[WIDTH-1:0];
            ovfRise    = !st_r.cnt[WIDTH-1] && sum[WIDTH-1];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            st_r <= pfm_pkg::CTR_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign value = st_r.cnt;
endmodule

/* hw/pfm_monitor.sv */
// Purpose: performance monitor with four event counters and sampled address
// Assumes: all core inputs come from logic on sys_clk; no synchronisers needed
// Notes:   register reads answer one cycle after the request
`timescale 1ns/1ps
module pfm_monitor (
    // clock and reset
    input  wire logic                    sys_clk,
    input  wire logic                    rst,
    // special-register move port
    input  wire logic [9:0]              sprNum,
    input  wire logic                    sprRead,
    input  wire logic                    sprWrite,
    input  wire logic                    sprUser,
    input  wire logic [31:0]             sprWdata,
    output logic      [31:0]             sprRdata,
    output logic                         sprRvalid,
    output logic                         sprFault,
    // core state
    input  wire logic                    privState,
    input  wire logic                    markBit,
    input  wire logic [31:0]             timeBaseLower,
    input  wire logic [1:0]              complCnt,
    input  wire logic [1:0]              dispCnt,
    input  wire logic [31:0]             lastComplEa,
    // threshold event from the load/store queues
    input  wire logic                    thrEvent,
    input  wire logic                    thrQueueHead,
    input  wire logic [31:0]             thrEa,
    // other events, three-bit amount per counter and code
    input  wire logic [3:0][31:0][2:0]   extEvents,
    // status
    output logic                         monitorIntr,
    output logic                         countActive
);
    typedef struct packed {
        logic [31:0] ctrlPri;
        logic [31:0] ctrlSec;
        logic [31:0] sampAddr;
        logic        tbPrev;
        logic [31:0] rdata;
        logic        rvalid;
        logic        fault;
        logic        intr;
        logic        active;
    } pfm_state_s;

    pfm_state_s        st_r;
    pfm_state_s        st_nxt;
    logic [3:0][31:0]  ctrVal;
    logic [3:0]        ctrOvf;
    logic [3:0]        ctrWr;
    logic [3:0][6:0]   ctrSel;
    logic [3:0][2:0]   ctrAmt;
    logic              countEn;
    logic              tbSel;
    logic              tbRise;
    logic              thrHit;
    logic              isUserReg;
    logic              isSupReg;

    // chosen event's amount for one counter this cycle
    function automatic logic [2:0] evtAmount(input logic [6:0]        sel,
                                             input logic [31:0][2:0]  ext,
                                             input logic              tb,
                                             input logic [1:0]        cmp,
                                             input logic [1:0]        dsp);
        logic [2:0] a;
        a = 3'h0;
        case (sel)
            pfm_pkg::EV_HOLD:     a = 3'h0;
            pfm_pkg::EV_CYCLES:   a = 3'h1;
            pfm_pkg::EV_COMPLETE: a = {1'b0, cmp};
            pfm_pkg::EV_TBRISE:   a = {2'b00, tb};
            pfm_pkg::EV_DISPATCH: a = {1'b0, dsp};
            default: begin
                if (sel < 7'(pfm_pkg::EXT_CODES)) begin
                    a = ext[sel[4:0]];
                end
            end
        endcase
        return a;
    endfunction

    always_comb begin
        ctrSel[0] = st_r.ctrlPri[pfm_pkg::CP_SEL1_LO +: 7];
        ctrSel[1] = {1'b0, st_r.ctrlPri[pfm_pkg::CP_SEL2_LO +: 6]};
        ctrSel[2] = {2'b00, st_r.ctrlSec[pfm_pkg::CS_SEL3_LO +: 5]};
        ctrSel[3] = {2'b00, st_r.ctrlSec[pfm_pkg::CS_SEL4_LO +: 5]};
    end

    always_comb begin
        countEn = 1'b1;
        if (st_r.ctrlPri[pfm_pkg::CP_DIS_SUP] && !privState) begin
            countEn = 1'b0;
        end
        if (st_r.ctrlPri[pfm_pkg::CP_DIS_USER] && privState) begin
            countEn = 1'b0;
        end
        if (st_r.ctrlPri[pfm_pkg::CP_DIS_MARK] && markBit) begin
            countEn = 1'b0;
        end
        if (st_r.ctrlPri[pfm_pkg::CP_DIS_UNMARK] && !markBit) begin
            countEn = 1'b0;
        end
        if (st_r.ctrlPri[pfm_pkg::CP_DIS]) begin
            countEn = 1'b0;
        end
    end

    always_comb begin
        case (st_r.ctrlPri[pfm_pkg::CP_TB_LO +: 2])
            2'b00:   tbSel = timeBaseLower[pfm_pkg::TB_BIT0];
            2'b01:   tbSel = timeBaseLower[pfm_pkg::TB_BIT1];
            2'b10:   tbSel = timeBaseLower[pfm_pkg::TB_BIT2];
            default: tbSel = timeBaseLower[pfm_pkg::TB_BIT3];
        endcase
    end

    assign tbRise = tbSel && !st_r.tbPrev;
    assign thrHit = thrEvent && thrQueueHead;

    always_comb begin
        for (int i = 0; i < 4; i++) begin
            ctrAmt[i] = 3'h0;
            if (countEn) begin
                ctrAmt[i] = evtAmount(ctrSel[i], extEvents[i], tbRise, complCnt, dispCnt);
            end
        end
        if (countEn && ctrSel[0] == pfm_pkg::EV_THRESHOLD) begin
            ctrAmt[0] = {2'b00, thrHit};
        end
    end

    always_comb begin
        ctrWr[0] = sprWrite && !sprUser && sprNum == pfm_pkg::SPR_CTR1;
        ctrWr[1] = sprWrite && !sprUser && sprNum == pfm_pkg::SPR_CTR2;
        ctrWr[2] = sprWrite && !sprUser && sprNum == pfm_pkg::SPR_CTR3;
        ctrWr[3] = sprWrite && !sprUser && sprNum == pfm_pkg::SPR_CTR4;
    end

    for (genvar g = 0; g < 4; g++) begin : gCtr
        pfm_counter #(.WIDTH(32)) uCtr (
            .sys_clk (sys_clk),
            .rst     (rst),
            .wrEn    (ctrWr[g]),
            .wrData  (sprWdata),
            .amount  (ctrAmt[g]),
            .value   (ctrVal[g]),
            .ovfRise (ctrOvf[g])
        );
    end

    always_comb begin
        isUserReg = sprNum inside {pfm_pkg::SPR_UCTR1, pfm_pkg::SPR_UCTR2, pfm_pkg::SPR_USAMP,
                                   pfm_pkg::SPR_UCTR3, pfm_pkg::SPR_UCTR4};
        isSupReg  = sprNum inside {pfm_pkg::SPR_CTRL_PRI, pfm_pkg::SPR_CTRL_SEC,
                                   pfm_pkg::SPR_CTR1, pfm_pkg::SPR_CTR2, pfm_pkg::SPR_CTR3,
                                   pfm_pkg::SPR_CTR4, pfm_pkg::SPR_SAMP};
    end

    always_comb begin
        st_nxt        = st_r;
        st_nxt.tbPrev = tbSel;
        st_nxt.rvalid = sprRead;
        st_nxt.fault  = 1'b0;
        st_nxt.rdata  = 32'h0000_0000;
        // overflow raises interrupt; pending while msb set
        st_nxt.intr   = ctrVal[0][31] | ctrVal[1][31] | ctrVal[2][31] | ctrVal[3][31];
        st_nxt.active = countEn;
        if (sprWrite && !sprUser) begin
            case (sprNum)
                pfm_pkg::SPR_CTRL_PRI: st_nxt.ctrlPri  = sprWdata;
                pfm_pkg::SPR_CTRL_SEC: st_nxt.ctrlSec  = sprWdata;
                pfm_pkg::SPR_SAMP:     st_nxt.sampAddr = sprWdata;
                default:               st_nxt.ctrlPri  = st_r.ctrlPri;
            endcase
        end
        if (sprWrite && (isUserReg || !isSupReg || sprUser)) begin
            st_nxt.fault = !isUserReg && !(isSupReg && !sprUser);
        end
        if (sprRead) begin
            case (sprNum)
                pfm_pkg::SPR_UCTR1:    st_nxt.rdata = ctrVal[0];
                pfm_pkg::SPR_UCTR2:    st_nxt.rdata = ctrVal[1];
                pfm_pkg::SPR_UCTR3:    st_nxt.rdata = ctrVal[2];
                pfm_pkg::SPR_UCTR4:    st_nxt.rdata = ctrVal[3];
                pfm_pkg::SPR_USAMP:    st_nxt.rdata = st_r.sampAddr;
                default:               st_nxt.rdata = 32'h0000_0000;
            endcase
            if (!sprUser) begin
                case (sprNum)
                    pfm_pkg::SPR_CTRL_PRI: st_nxt.rdata = st_r.ctrlPri;
                    pfm_pkg::SPR_CTRL_SEC: st_nxt.rdata = st_r.ctrlSec;
                    pfm_pkg::SPR_CTR1:     st_nxt.rdata = ctrVal[0];
                    pfm_pkg::SPR_CTR2:     st_nxt.rdata = ctrVal[1];
                    pfm_pkg::SPR_CTR3:     st_nxt.rdata = ctrVal[2];
                    pfm_pkg::SPR_CTR4:     st_nxt.rdata = ctrVal[3];
                    pfm_pkg::SPR_SAMP:     st_nxt.rdata = st_r.sampAddr;
                    default:               st_nxt.rdata = st_nxt.rdata;
                endcase
            end
            st_nxt.fault = !isUserReg && !(isSupReg && !sprUser);
        end
        // capture on overflow, beats a software write
        if (|ctrOvf) begin
            // exact threshold instruction; split accesses not exact
            if (ctrOvf[0] && ctrSel[0] == pfm_pkg::EV_THRESHOLD && !ctrWr[0]) begin
                st_nxt.sampAddr = thrEa;
            end else begin
                st_nxt.sampAddr = lastComplEa;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            st_r          <= '0;
            st_r.ctrlPri  <= pfm_pkg::CTRL_PRI_RST;
            st_r.ctrlSec  <= pfm_pkg::CTRL_SEC_RST;
            st_r.sampAddr <= pfm_pkg::SAMP_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign sprRdata    = st_r.rdata;
    assign sprRvalid   = st_r.rvalid;
    assign sprFault    = st_r.fault;
    assign monitorIntr = st_r.intr;
    assign countActive = st_r.active;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    sequence sUserRead1;
        sprRead && sprNum == pfm_pkg::SPR_UCTR1;
    endsequence
    sequence sThrOvf;
        ctrOvf[0] && ctrSel[0] == pfm_pkg::EV_THRESHOLD && !ctrWr[0];
    endsequence
    sequence sPlainOvf;
        (|ctrOvf) && !(ctrOvf[0] && ctrSel[0] == pfm_pkg::EV_THRESHOLD && !ctrWr[0]);
    endsequence

    AST_MIRROR_READ: assert property (sUserRead1 |=> sprRvalid && sprRdata == $past(ctrVal[0]))
        else $error("user view of counter one read wrong");
    AST_SAMP_MIRROR: assert property (sprRead && sprNum == pfm_pkg::SPR_USAMP
        |=> sprRdata == $past(st_r.sampAddr)) else $error("sampled address view wrong");
    AST_SAMP_THR: assert property (sThrOvf |=> st_r.sampAddr == $past(thrEa))
        else $error("threshold overflow did not capture its address");
    AST_SAMP_LAST: assert property (sPlainOvf |=> st_r.sampAddr == $past(lastComplEa))
        else $error("overflow did not capture last completed address");
    AST_DISABLE: assert property (st_r.ctrlPri[pfm_pkg::CP_DIS] |-> !countEn
        ##1 (countActive == 1'b0)) else $error("counting while disabled");
    AST_UNCOND: assert property (st_r.ctrlPri[31:27] == 5'h00 |-> countEn)
        else $error("counting blocked with no conditions set");
    AST_SUP_ONLY: assert property (st_r.ctrlPri[31:27] == 5'h04 |-> countEn == !privState)
        else $error("supervisor-only state match wrong");
    AST_CYCLES: assert property (countEn && ctrSel[1] == pfm_pkg::EV_CYCLES && !ctrWr[1]
        && ctrVal[1] != 32'hFFFF_FFFF |=> ctrVal[1] == $past(ctrVal[1]) + 32'h0000_0001)
        else $error("cycle code did not add one");
    AST_HOLD: assert property (ctrSel[2] == pfm_pkg::EV_HOLD && !ctrWr[2]
        |=> $stable(ctrVal[2])) else $error("hold code changed counter");
    AST_INTR: assert property (ctrVal[3][31] |=> monitorIntr)
        else $error("msb set without interrupt condition");
    AST_INTR_HOLD: assert property (monitorIntr && ctrVal == $past(ctrVal) |-> ##1 monitorIntr)
        else $error("interrupt condition dropped without rewrite");
endmodule

/* test/pfm_core_model.sv */
// Purpose: core pipeline stand-in that feeds the performance monitor
// Assumes: outputs change 1 ns after the rising edge of sys_clk
// Notes:   the bench picks the address, time-base step and event amount
`timescale 1ns/1ps
module pfm_core_model (
    // clock and reset
    input  wire logic                  sys_clk,
    input  wire logic                  rst,
    // bench commands
    input  wire logic [31:0]           tbStep,
    input  wire logic [31:0]           eaCmd,
    input  wire logic [2:0]            extAmt,
    // core outputs
    output logic      [31:0]           timeBaseLower,
    output logic      [1:0]            complCnt,
    output logic      [1:0]            dispCnt,
    output logic      [31:0]           lastComplEa,
    output logic      [3:0][31:0][2:0] extEvents
);
    always @(posedge sys_clk) begin
        if (rst) begin
            timeBaseLower <= #1 32'h0000_0000;
        end else begin
            timeBaseLower <= #1 timeBaseLower + tbStep;
        end
    end
    assign complCnt    = 2'h2;
    assign dispCnt     = 2'h1;
    assign lastComplEa = eaCmd;
    always_comb begin
        extEvents = '0;
        for (int c = 0; c < 4; c++) begin
            extEvents[c][5] = extAmt;
        end
    end
endmodule

/* test/pfm_testbench.sv */
// Purpose: self-checking bench for the performance monitor
// Assumes: pfm_core_model stands in for the core pipeline
// Notes:   count steps are judged over reads taken two edges apart
`timescale 1ns/1ps
module testbench;
    logic                  sysClk       = 1'b0;
    logic                  rst          = 1'b1;
    logic [9:0]            sprNum       = 10'h000;
    logic                  sprRead      = 1'b0;
    logic                  sprWrite     = 1'b0;
    logic                  sprUser      = 1'b0;
    logic [31:0]           sprWdata     = 32'h0000_0000;
    logic                  privState    = 1'b0;
    logic                  markBit      = 1'b0;
    logic                  thrEvent     = 1'b0;
    logic                  thrQueueHead = 1'b0;
    logic [31:0]           thrEa        = 32'h0000_0000;
    logic [31:0]           tbStep       = 32'h0000_0001;
    logic [31:0]           eaCmd        = 32'h0000_0000;
    logic [2:0]            extAmt       = 3'h3;
    logic [31:0]           sprRdata;
    logic                  sprRvalid;
    logic                  sprFault;
    logic                  monitorIntr;
    logic                  countActive;
    logic [31:0]           timeBaseLower;
    logic [31:0]           lastComplEa;
    logic [1:0]            complCnt;
    logic [1:0]            dispCnt;
    logic [3:0][31:0][2:0] extEvents;
    int                    badCount     = 0;
    int                    checkCount   = 0;

    always #20 sysClk = ~sysClk;

    pfm_core_model coreModel (.sys_clk(sysClk), .rst(rst), .tbStep(tbStep), .eaCmd(eaCmd),
        .extAmt(extAmt), .timeBaseLower(timeBaseLower), .complCnt(complCnt),
        .dispCnt(dispCnt), .lastComplEa(lastComplEa), .extEvents(extEvents));

    pfm_monitor dut (.sys_clk(sysClk), .rst(rst), .sprNum(sprNum), .sprRead(sprRead),
        .sprWrite(sprWrite), .sprUser(sprUser), .sprWdata(sprWdata), .sprRdata(sprRdata),
        .sprRvalid(sprRvalid), .sprFault(sprFault), .privState(privState),
        .markBit(markBit), .timeBaseLower(timeBaseLower), .complCnt(complCnt),
        .dispCnt(dispCnt), .lastComplEa(lastComplEa), .thrEvent(thrEvent),
        .thrQueueHead(thrQueueHead), .thrEa(thrEa), .extEvents(extEvents),
        .monitorIntr(monitorIntr), .countActive(countActive));

    task automatic finishTest();
        $display("checks %0d mismatches %0d", checkCount, badCount);
        if (badCount == 0 && checkCount > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checkCount++;
        if (seen !== exp) begin
            badCount++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wr(input logic [9:0] num, input logic [31:0] data);
        @(posedge sysClk);
        #1;
        sprNum   = num;
        sprWdata = data;
        sprWrite = 1'b1;
        @(posedge sysClk);
        #1;
        sprWrite = 1'b0;
    endtask

    task automatic rd(input logic [9:0] num, output logic [31:0] val);
        int j;
        @(posedge sysClk);
        #1;
        sprNum  = num;
        sprRead = 1'b1;
        @(posedge sysClk);
        #1;
        sprRead = 1'b0;
        j = 0;
        while (sprRvalid !== 1'b1 && j < 8) begin
            @(posedge sysClk);
            #1;
            j++;
        end
        if (j == 8) begin
            badCount++;
            finishTest();
        end
        val = sprRdata;
    endtask

    task automatic readCheck(input logic [9:0] num, input logic [31:0] exp);
        logic [31:0] v;
        rd(num, v);
        check("register read", v, exp);
    endtask

    // counts seen over two reads taken two edges apart
    task automatic delta(input logic [9:0] num, input logic [31:0] exp);
        logic [31:0] a;
        logic [31:0] b;
        rd(num, a);
        rd(num, b);
        check("count step", b - a, exp);
    endtask

    task automatic waitIntr(input logic level);
        int j;
        j = 0;
        while (monitorIntr !== level && j < 8) begin
            @(posedge sysClk);
            #1;
            j++;
        end
        check("monitor interrupt", {31'h0, monitorIntr}, {31'h0, level});
        if (j == 8) begin
            finishTest();
        end
    endtask

    task automatic thrPulse(input logic head, input logic [31:0] ea);
        @(posedge sysClk);
        #1;
        thrEvent     = 1'b1;
        thrQueueHead = head;
        thrEa        = ea;
        @(posedge sysClk);
        #1;
        thrEvent     = 1'b0;
    endtask

    task automatic testReset();
        logic [9:0] views [5] = '{pfm_pkg::SPR_UCTR1, pfm_pkg::SPR_UCTR2, pfm_pkg::SPR_USAMP,
                                  pfm_pkg::SPR_UCTR3, pfm_pkg::SPR_UCTR4};
        sprUser = 1'b1;
        foreach (views[i]) begin
            readCheck(views[i], 32'h0000_0000);
            check("view fault", {31'h0, sprFault}, 32'h0);
        end
        readCheck(pfm_pkg::SPR_CTR1, 32'h0000_0000);
        check("user fault", {31'h0, sprFault}, 32'h1);
        sprUser = 1'b0;
        wr(pfm_pkg::SPR_UCTR1, 32'h1234_5678);
        readCheck(pfm_pkg::SPR_UCTR1, 32'h0000_0000);
        wr(pfm_pkg::SPR_SAMP, 32'hCAFE_0000);
        readCheck(pfm_pkg::SPR_SAMP, 32'hCAFE_0000);
        readCheck(pfm_pkg::SPR_USAMP, 32'hCAFE_0000);
        $display("test reset and views done");
    endtask

    task automatic testCodes();
        logic [9:0]  views [4] = '{pfm_pkg::SPR_UCTR1, pfm_pkg::SPR_UCTR2,
                                   pfm_pkg::SPR_UCTR3, pfm_pkg::SPR_UCTR4};
        logic [31:0] codes [6] = '{32'h0, 32'h1, 32'h2, 32'h3, 32'h4, 32'h5};
        logic [31:0] steps [6] = '{32'h0, 32'h2, 32'h4, 32'h1, 32'h2, 32'h6};
        for (int c = 0; c < 4; c++) begin
            for (int k = 0; k < 6; k++) begin
                wr(pfm_pkg::SPR_CTRL_PRI, c == 0 ? codes[k] << 6 : c == 1 ? codes[k] : 32'h0);
                wr(pfm_pkg::SPR_CTRL_SEC, c == 2 ? codes[k] << 27
                                                 : c == 3 ? codes[k] << 22 : 32'h0);
                delta(views[c], steps[k]);
            end
        end
        $display("test event codes done");
    endtask

    task automatic testTimeBase();
        int bitPos [4] = '{0, 8, 12, 16};
        wr(pfm_pkg::SPR_CTRL_SEC, 32'h0000_0000);
        for (int ch = 0; ch < 4; ch++) begin
            tbStep = 32'h1 << bitPos[ch];
            wr(pfm_pkg::SPR_CTRL_PRI, (32'(ch) << 23) | (32'h3 << 6));
            delta(pfm_pkg::SPR_UCTR1, 32'h0000_0001);
        end
        wr(pfm_pkg::SPR_CTRL_PRI, 32'h3 << 6);
        delta(pfm_pkg::SPR_UCTR1, 32'h0000_0000);
        tbStep = 32'h0000_0001;
        $display("test time base done");
    endtask

    task automatic testGating();
        logic act;
        for (int m = 0; m < 32; m++) begin
            for (int s = 0; s < 4; s++) begin
                privState = s[0];
                markBit   = s[1];
                wr(pfm_pkg::SPR_CTRL_PRI, (32'(m) << 27) | (32'h1 << 6));
                act = !(m[4] | (m[3] & !s[0]) | (m[2] & s[0]) | (m[1] & s[1]) | (m[0] & !s[1]));
                delta(pfm_pkg::SPR_UCTR1, act ? 32'h2 : 32'h0);
                check("count active", {31'h0, countActive}, {31'h0, act});
            end
        end
        privState = 1'b0;
        markBit   = 1'b0;
        $display("test state gating done");
    endtask

    task automatic testOverflow();
        eaCmd = 32'h0000_1F00;
        wr(pfm_pkg::SPR_CTRL_PRI, 32'h1 << 6);
        wr(pfm_pkg::SPR_CTR1, 32'h7FFF_FFFF);
        waitIntr(1'b1);
        readCheck(pfm_pkg::SPR_SAMP, 32'h0000_1F00);
        readCheck(pfm_pkg::SPR_USAMP, 32'h0000_1F00);
        repeat (5) @(posedge sysClk);
        check("interrupt held", {31'h0, monitorIntr}, 32'h1);
        wr(pfm_pkg::SPR_CTRL_PRI, 32'h0000_0000);
        wr(pfm_pkg::SPR_CTR1, 32'h0000_0000);
        waitIntr(1'b0);
        $display("test overflow done");
    endtask

    task automatic testThreshold();
        eaCmd = 32'h0000_2000;
        wr(pfm_pkg::SPR_CTRL_PRI, 32'(pfm_pkg::EV_THRESHOLD) << 6);
        wr(pfm_pkg::SPR_CTR1, 32'h7FFF_FFFF);
        thrPulse(1'b0, 32'h0000_3000);
        readCheck(pfm_pkg::SPR_UCTR1, 32'h7FFF_FFFF);
        check("no interrupt", {31'h0, monitorIntr}, 32'h0);
        thrPulse(1'b1, 32'h0000_4000);
        waitIntr(1'b1);
        readCheck(pfm_pkg::SPR_SAMP, 32'h0000_4000);
        wr(pfm_pkg::SPR_CTR1, 32'h0000_0000);
        $display("test threshold done");
    endtask

    initial begin
        repeat (20) @(posedge sysClk);
        #1;
        rst = 1'b0;
        testReset();
        testCodes();
        testTimeBase();
        testGating();
        testOverflow();
        testThreshold();
        finishTest();
    end
endmodule
